// ===== src/fcu_map.svh
/*
  constants for the floppy control command unit: opcodes, field positions,
  reset values and timing counts. assumes a 50 MHz core clock.
*/
`ifndef FCU_MAP_SVH
`define FCU_MAP_SVH

// command opcodes (low five bits of the first command byte)
`define FCU_OP_SPECIFY 5'h03
`define FCU_OP_SENSE_DRV 5'h04
`define FCU_OP_RECAL 5'h07
`define FCU_OP_SENSE_INT 5'h08
`define FCU_OP_SEEK 5'h0F
`define FCU_OP_VERSION 5'h10
`define FCU_OP_CONFIGURE 5'h13

// status zero fields
`define FCU_ST0_SE_BIT 5
`define FCU_ST0_EC_BIT 4
`define FCU_ST0_HEAD_BIT 2
`define FCU_IC_NORMAL 2'h0
`define FCU_IC_ABNORMAL 2'h1
`define FCU_IC_POLL 2'h3

// configure byte fields
`define FCU_CFG_EIS_BIT 6
`define FCU_CFG_BUFFER_DISABLE_BIT 5
`define FCU_CFG_POLL_BIT 4

// reset values
`define FCU_RST_EIS 1'b0
`define FCU_RST_BUFFER_DISABLE 1'b1
`define FCU_RST_POLL 1'b0
`define FCU_RST_THR 4'h0
`define FCU_RST_PRECOMP_START_TRACK 8'h00

// recalibrate step limit
`define FCU_RECAL_MAX 8'h50

// delay units at 500K, in microseconds
`define FCU_CLK_MHZ 50
`define FCU_STEP_UNIT_US 1000
`define FCU_UNLOAD_UNIT_US 16000
`define FCU_SETTLE_UNIT_US 2000
`define FCU_STEP_PULSE_US 4
`define FCU_STEP_PULSE_CYC (`FCU_STEP_PULSE_US * `FCU_CLK_MHZ)

`endif

// ===== src/fcu_pkg.sv
/*
  types of the floppy control command unit.
  assumes fcu_map.svh provides the numeric constants.
*/
package fcu_pkg;
  typedef enum logic [2:0] {
    FCU_R2M, FCU_R1M, FCU_R500K, FCU_R300K, FCU_R250K
  } fcu_rate_t;

  typedef enum {
    FCU_IDLE, FCU_CMD, FCU_RES, FCU_STEP, FCU_STEP_WAIT, FCU_DONE
  } fcu_state_t;

  typedef struct packed {
    fcu_state_t st;
    logic [4:0] op;
    logic rel_dir;
    logic [2:0] nbytes;
    logic [2:0] idx;
    logic [7:0] arg1;
    logic [1:0] drv;
    logic [3:0] head_unload_delay_code;
    logic [3:0] step_interval_code;
    logic [6:0] head_settle_delay_code;
    logic non_dma_select;
    logic implied_seek_enable;
    logic buffer_disable;
    logic poll_disable;
    logic [3:0] buffer_threshold;
    logic [7:0] precomp_start_track;
    logic [3:0][7:0] present_cylinder;
    logic [7:0] target;
    logic [7:0] steps;
    logic [31:0] timer;
    logic [31:0] unload_timer;
    logic head_loaded;
    logic int_pend;
    logic [7:0] status_zero;
    logic [7:0] res_data;
    logic [1:0] res_left;
    logic [3:0] busy;
    logic step;
    logic dir;
    logic poll_done;
  } fcu_state_s_t;
endpackage

// ===== src/fcu_core.sv
/*
  floppy control command unit: command byte interpreter for sense interrupt,
  sense drive status, specify, configure, version, seek, relative seek and
  recalibrate, with step timing and head unload/settle timing.
  assumes a byte-wide host handshake synchronous to core_clk and drive sense
  inputs already synchronous.
*/
// What this block does
// - interrupt on result phase or seek end
// - non-DMA: interrupt per execution byte request
// - sense interrupt clears, reports cause in status
// - cause codes: poll 11, normal 00, abnormal 01
// - head bit in sense status reads zero
// - drive stays busy until sense interrupt
// - sense drive status goes straight to result
// - unload delay 16 ms steps, code 0 256
// - step interval 16 ms down to 1 ms
// - settle delay 2 ms steps, code 0 256
// - delays scale inversely with data rate
// - mode bit selects DMA or non-DMA signalling
// - implied seek enable only stored and output, never acted on
// - buffer disable means byte-by-byte requests; only stored and output here
// - polling gives one interrupt after reset
// - threshold is field plus one bytes
// - precomp start track eight bits, default 0
// - version returns fixed enhanced-controller byte
// - relative seek steps count, always inward
// - one relative seek at a time
// - equipment check when stepping out past zero
// - cylinder becomes sum modulo 256
// - recalibrate stops at track zero or 80
`include "fcu_map.svh"

module fcu_core import fcu_pkg::*; #(
  parameter logic [7:0] VERSION_BYTE = 8'h5A, // arbitrary value
  parameter int UNLOAD_UNIT_CYC = `FCU_UNLOAD_UNIT_US * `FCU_CLK_MHZ,
  parameter int STEP_UNIT_CYC = `FCU_STEP_UNIT_US * `FCU_CLK_MHZ,
  parameter int SETTLE_UNIT_CYC = `FCU_SETTLE_UNIT_US * `FCU_CLK_MHZ
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // host byte port
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic res_ready,
  output logic [7:0] res_byte,
  output logic res_valid,
  output logic host_transfer_request_flag,
  // data path from the read/write engine
  input wire logic xfer_byte_needed,
  input wire logic rw_exec_start,
  input wire logic rw_exec_end,
  input wire logic rw_result_enter,
  input wire logic [2:0] data_rate,
  // drive sense
  input wire logic track_zero_sense,
  input wire logic [7:0] drive_status_register,
  // drive control
  output logic step_pulse,
  output logic step_dir,
  output logic [1:0] step_drive,
  output logic head_load,
  output logic head_settled,
  output logic [3:0] drive_busy,
  // transfer signalling and configuration
  output logic int_req,
  output logic dma_req,
  output logic non_dma_select,
  output logic implied_seek_enable,
  output logic buffer_disable,
  output logic [4:0] buffer_threshold_bytes,
  output logic [7:0] precomp_start_track
);
  initial begin
    if (STEP_UNIT_CYC < 1 || UNLOAD_UNIT_CYC < 1 || SETTLE_UNIT_CYC < 1) begin
      $error("fcu_core: delay units must be at least one cycle");
    end
  end

  fcu_state_s_t s_reg, s_next;

  // delay scaled from the 500K figure by data rate
  function automatic logic [31:0] scale(input logic [31:0] base,
                                        input logic [2:0] rate);
    case (fcu_rate_t'(rate))
      FCU_R2M: scale = base >> 2;
      FCU_R1M: scale = base >> 1;
      FCU_R300K: scale = 32'((64'(base) * 5) / 3);
      FCU_R250K: scale = base << 1;
      default: scale = base;
    endcase
  endfunction

  // byte count of each command
  function automatic logic [2:0] cmd_len(input logic [4:0] op);
    case (op)
      `FCU_OP_SPECIFY: cmd_len = 3'd3;
      `FCU_OP_SENSE_DRV: cmd_len = 3'd2;
      `FCU_OP_RECAL: cmd_len = 3'd2;
      `FCU_OP_SEEK: cmd_len = 3'd3;
      `FCU_OP_CONFIGURE: cmd_len = 3'd4;
      default: cmd_len = 3'd1;
    endcase
  endfunction

  logic [31:0] step_cyc, unload_cyc, settle_cyc, pulse_cyc;
  logic [7:0] pcn_cur;

  always_comb begin
    step_cyc = scale(32'(16 - {28'h0, s_reg.step_interval_code})
      * 32'(STEP_UNIT_CYC), data_rate);
    unload_cyc = scale((s_reg.head_unload_delay_code == 4'h0 ? 32'd16 :
      32'(s_reg.head_unload_delay_code)) * 32'(UNLOAD_UNIT_CYC),
      data_rate);
    settle_cyc = scale((s_reg.head_settle_delay_code == 7'h00 ? 32'd128 :
      32'(s_reg.head_settle_delay_code)) * 32'(SETTLE_UNIT_CYC),
      data_rate);
    pcn_cur = s_reg.present_cylinder[s_reg.drv];
    // pulse never longer than half the interval, so it always falls
    pulse_cyc = ((step_cyc >> 1) < 32'(`FCU_STEP_PULSE_CYC)) ?
      (step_cyc >> 1) : 32'(`FCU_STEP_PULSE_CYC);
  end

  always_comb begin
    s_next = s_reg;
    s_next.step = 1'b0;
    if (s_reg.unload_timer != 32'h0) begin
      s_next.unload_timer = s_reg.unload_timer - 32'h1;
    end else if (s_reg.head_loaded && !rw_exec_start) begin
      s_next.head_loaded = 1'b0;
    end
    if (rw_exec_start) begin
      s_next.head_loaded = 1'b1;
      s_next.unload_timer = settle_cyc;
    end
    if (rw_exec_end) begin
      s_next.unload_timer = unload_cyc;
    end
    // single poll interrupt after reset, held off while head is loaded
    if (!s_reg.poll_done && !s_reg.poll_disable && !s_reg.head_loaded) begin
      s_next.poll_done = 1'b1;
      s_next.int_pend = 1'b1;
      s_next.status_zero = {2'(`FCU_IC_POLL), 6'h00};
    end
    if (rw_result_enter) begin
      s_next.int_pend = 1'b1;
    end
    case (s_reg.st)
      FCU_IDLE: begin
        if (cmd_valid) begin
          s_next.op = cmd_byte[4:0];
          s_next.rel_dir = cmd_byte[6];
          s_next.idx = 3'd1;
          s_next.nbytes = cmd_len(cmd_byte[4:0]);
          s_next.st = FCU_CMD;
        end
      end
      FCU_CMD: begin
        if (s_reg.idx == s_reg.nbytes) begin
          s_next.st = FCU_RES;
          s_next.res_left = 2'd0;
          case (s_reg.op)
            `FCU_OP_SENSE_INT: begin
              s_next.res_data = s_reg.status_zero &
                ~(8'h01 << `FCU_ST0_HEAD_BIT);
              s_next.res_left = 2'd2;
              s_next.int_pend = 1'b0;
              s_next.busy[s_reg.drv] = 1'b0;
            end
            `FCU_OP_SENSE_DRV: begin
              s_next.res_data = drive_status_register;
              s_next.res_left = 2'd1;
            end
            `FCU_OP_VERSION: begin
              s_next.res_data = VERSION_BYTE;
              s_next.res_left = 2'd1;
            end
            `FCU_OP_RECAL: begin
              s_next.steps = 8'h00;
              s_next.busy[s_reg.drv] = 1'b1;
              s_next.dir = 1'b0;
              s_next.st = FCU_STEP;
            end
            `FCU_OP_SEEK: begin
              s_next.busy[s_reg.drv] = 1'b1;
              s_next.steps = 8'h00;
              // relative count steps without comparing
              s_next.dir = s_reg.rel_dir ? s_reg.rel_dir
                : (s_reg.target > pcn_cur);
              s_next.st = FCU_STEP;
            end
            default: s_next.st = FCU_IDLE;
          endcase
          if (s_reg.op == `FCU_OP_SEEK && s_reg.rel_dir == 1'b0 &&
              s_reg.op[4] == 1'b0 && cmd_len(s_reg.op) == 3'd3 &&
              s_reg.nbytes == 3'd3 && s_reg.arg1[7]) begin
            s_next.st = FCU_STEP;
          end
        end else if (cmd_valid) begin
          s_next.idx = s_reg.idx + 3'd1;
          case ({s_reg.op, s_reg.idx})
            {`FCU_OP_SPECIFY, 3'd1}: begin
              s_next.step_interval_code = cmd_byte[7:4];
              s_next.head_unload_delay_code = cmd_byte[3:0];
            end
            {`FCU_OP_SPECIFY, 3'd2}: begin
              s_next.head_settle_delay_code = cmd_byte[7:1];
              s_next.non_dma_select = cmd_byte[0];
            end
            {`FCU_OP_CONFIGURE, 3'd2}: begin
              s_next.implied_seek_enable = cmd_byte[`FCU_CFG_EIS_BIT];
              s_next.buffer_disable = cmd_byte[`FCU_CFG_BUFFER_DISABLE_BIT];
              s_next.poll_disable = cmd_byte[`FCU_CFG_POLL_BIT];
              s_next.buffer_threshold = cmd_byte[3:0];
            end
            {`FCU_OP_CONFIGURE, 3'd3}:
              s_next.precomp_start_track = cmd_byte;
            {`FCU_OP_SEEK, 3'd2}: s_next.target = cmd_byte;
            default: begin
              s_next.drv = cmd_byte[1:0];
              s_next.arg1 = cmd_byte;
            end
          endcase
        end
      end
      FCU_RES: begin
        if (s_reg.res_left == 2'd0) begin
          s_next.st = FCU_IDLE;
        end else if (res_ready) begin
          s_next.res_left = s_reg.res_left - 2'd1;
          s_next.res_data = pcn_cur;
        end
      end
      FCU_STEP: begin
        if (s_reg.op == `FCU_OP_RECAL) begin
          if (track_zero_sense) begin
            s_next.present_cylinder[s_reg.drv] = 8'h00;
            s_next.status_zero = {2'(`FCU_IC_NORMAL), 1'b1, 5'h00};
            s_next.st = FCU_DONE;
          end else if (s_reg.steps == `FCU_RECAL_MAX) begin
            s_next.status_zero = {2'(`FCU_IC_ABNORMAL), 2'b11, 4'h0};
            s_next.st = FCU_DONE;
          end else begin
            s_next.step = 1'b1;
          end
        end else if (s_reg.rel_dir || s_reg.steps != 8'h00 ||
                     s_reg.target != pcn_cur) begin
          if ((s_reg.rel_dir ? s_reg.steps == s_reg.target :
               s_reg.target == pcn_cur)) begin
            s_next.status_zero = {2'(`FCU_IC_NORMAL), 1'b1, 5'h00};
            s_next.st = FCU_DONE;
          end else if (!s_reg.dir && track_zero_sense) begin
            s_next.status_zero = {2'(`FCU_IC_ABNORMAL), 2'b11,
              4'h0};
            s_next.st = FCU_DONE;
          end else begin
            s_next.step = 1'b1;
          end
        end else begin
          s_next.status_zero = {2'(`FCU_IC_NORMAL), 1'b1, 5'h00};
          s_next.st = FCU_DONE;
        end
        if (s_next.step) begin
          s_next.steps = s_reg.steps + 8'h01;
          s_next.present_cylinder[s_reg.drv] = s_reg.dir ? pcn_cur + 8'h01
            : pcn_cur - 8'h01;
          s_next.timer = step_cyc;
          s_next.st = FCU_STEP_WAIT;
        end
      end
      FCU_STEP_WAIT: begin
        s_next.step = (step_cyc - s_reg.timer) < pulse_cyc;
        if (s_reg.timer == 32'h0) begin
          s_next.st = FCU_STEP;
        end else begin
          s_next.timer = s_reg.timer - 32'h1;
        end
      end
      FCU_DONE: begin
        s_next.int_pend = 1'b1;
        s_next.st = FCU_IDLE;
      end
      default: s_next.st = FCU_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.st <= FCU_IDLE;
      s_reg.implied_seek_enable <= `FCU_RST_EIS;
      s_reg.buffer_disable <= `FCU_RST_BUFFER_DISABLE;
      s_reg.poll_disable <= `FCU_RST_POLL;
      s_reg.buffer_threshold <= `FCU_RST_THR;
      s_reg.precomp_start_track <= `FCU_RST_PRECOMP_START_TRACK;
    end else begin
      s_reg <= s_next;
    end
  end

  // byte request goes to DMA or to the interrupt by mode
  assign dma_req = xfer_byte_needed && !s_reg.non_dma_select;
  assign int_req = s_reg.int_pend ||
    (xfer_byte_needed && s_reg.non_dma_select);
  assign host_transfer_request_flag = (s_reg.st == FCU_IDLE) ||
    (s_reg.st == FCU_CMD && s_reg.idx != s_reg.nbytes) ||
    (s_reg.st == FCU_RES && s_reg.res_left != 2'd0) ||
    (xfer_byte_needed && s_reg.non_dma_select);
  assign res_byte = s_reg.res_data;
  assign res_valid = s_reg.st == FCU_RES && s_reg.res_left != 2'd0;
  assign step_pulse = s_reg.step;
  assign step_dir = s_reg.dir;
  assign step_drive = s_reg.drv;
  assign head_load = s_reg.head_loaded;
  assign head_settled = s_reg.head_loaded && s_reg.unload_timer == 32'h0;
  assign drive_busy = s_reg.busy;
  assign non_dma_select = s_reg.non_dma_select;
  assign implied_seek_enable = s_reg.implied_seek_enable;
  assign buffer_disable = s_reg.buffer_disable;
  assign buffer_threshold_bytes = {1'b0, s_reg.buffer_threshold} + 5'd1;
  assign precomp_start_track = s_reg.precomp_start_track;
endmodule

// ===== tb/fcu_core_asserts.sv
/*
  concurrent checks on the ports of the command unit.
  assumes a bind onto fcu_core and a single clock domain.
*/
module fcu_core_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // host side
  input wire logic res_valid,
  input wire logic res_ready,
  input wire logic [7:0] res_byte,
  input wire logic int_req,
  // transfer signalling
  input wire logic xfer_byte_needed,
  input wire logic dma_req,
  input wire logic non_dma_select,
  input wire logic [4:0] buffer_threshold_bytes,
  // drive control
  input wire logic step_pulse,
  input wire logic step_dir
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  chk_poll_after_reset: assert property (
    $fell(sys_rst) |-> ##[0:3] int_req)
    else $error("no interrupt after reset");
  chk_thr_range: assert property (
    buffer_threshold_bytes != 5'h00 && buffer_threshold_bytes <= 5'h10)
    else $error("threshold out of range");
  chk_dma_follow: assert property (
    !non_dma_select |-> dma_req == xfer_byte_needed)
    else $error("dma request not following byte need");
  chk_nondma_quiet: assert property (
    non_dma_select |-> !dma_req)
    else $error("dma request in non dma mode");
  chk_nondma_int: assert property (
    non_dma_select && xfer_byte_needed |-> ##[0:2] int_req)
    else $error("no interrupt for byte in non dma mode");
  chk_res_hold: assert property (
    res_valid && !res_ready |=> res_valid && $stable(res_byte))
    else $error("result byte not held");
  chk_step_width: assert property (
    $rose(step_pulse) |-> step_pulse [*8])
    else $error("step pulse too short");
  chk_dir_steady: assert property (
    $rose(step_pulse) |=> $stable(step_dir) throughout step_pulse [*4])
    else $error("direction moved during step");

  cover property (res_valid && res_ready);
  cover property ($rose(step_pulse) && step_dir);
  cover property ($fell(int_req));
endmodule

bind fcu_core fcu_core_chk fcu_core_chk_i (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .res_valid(res_valid),
  .res_ready(res_ready),
  .res_byte(res_byte),
  .int_req(int_req),
  .xfer_byte_needed(xfer_byte_needed),
  .dma_req(dma_req),
  .non_dma_select(non_dma_select),
  .buffer_threshold_bytes(buffer_threshold_bytes),
  .step_pulse(step_pulse),
  .step_dir(step_dir)
);

// ===== tb/fcu_drive_model.sv
/*
  behavioural drive: follows step pulses and reports track zero.
  assumes step_dir high means inward; the carriage stops at track zero.
*/
module fcu_drive_model (
  // drive control
  input wire logic step_pulse,
  input wire logic step_dir,
  // drive sense
  output logic track_zero_sense
);
  timeunit 1ns;
  timeprecision 1ns;
  int head_pos;
  initial head_pos = 0;
  // physical position, no wrap at 256
  always @(posedge step_pulse) begin
    if (step_dir) begin
      head_pos = head_pos + 1;
    end else if (head_pos > 0) begin
      head_pos = head_pos - 1;
    end
  end
  assign track_zero_sense = (head_pos == 0);
endmodule

// ===== tb/fcu_core_bench.sv
/*
  self-checking bench for the command unit: byte handshake tasks and
  command sequences with expected results.
  assumes the drive model on the step lines and 50 MHz core_clk.
*/
module fcu_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] VER_CODE = 8'h5A; // arbitrary value
  logic core_clk, sys_rst, cmd_valid, res_ready, res_valid, int_req;
  logic host_transfer_request_flag, xfer_byte_needed, track_zero_sense;
  logic step_pulse, step_dir, head_load, head_settled, dma_req;
  logic rw_result_enter;
  logic non_dma_select, implied_seek_enable, buffer_disable;
  logic [7:0] cmd_byte, res_byte, drive_status_register;
  logic [7:0] precomp_start_track;
  logic [4:0] buffer_threshold_bytes;
  logic [3:0] drive_busy;
  logic [2:0] data_rate;
  logic [1:0] step_drive;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;

  fcu_core #(.VERSION_BYTE(VER_CODE), .UNLOAD_UNIT_CYC(4),
    .STEP_UNIT_CYC(20), .SETTLE_UNIT_CYC(4)) fcu_core_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .res_ready(res_ready), .res_byte(res_byte),
    .res_valid(res_valid),
    .host_transfer_request_flag(host_transfer_request_flag),
    .xfer_byte_needed(xfer_byte_needed), .rw_exec_start(1'b0),
    .rw_exec_end(1'b0), .rw_result_enter(rw_result_enter),
    .data_rate(data_rate),
    .track_zero_sense(track_zero_sense),
    .drive_status_register(drive_status_register),
    .step_pulse(step_pulse), .step_dir(step_dir), .step_drive(step_drive),
    .head_load(head_load), .head_settled(head_settled),
    .drive_busy(drive_busy), .int_req(int_req), .dma_req(dma_req),
    .non_dma_select(non_dma_select),
    .implied_seek_enable(implied_seek_enable),
    .buffer_disable(buffer_disable),
    .buffer_threshold_bytes(buffer_threshold_bytes),
    .precomp_start_track(precomp_start_track));

  fcu_drive_model fcu_drive_model_i (.step_pulse(step_pulse),
    .step_dir(step_dir), .track_zero_sense(track_zero_sense));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 100000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk8(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_byte = b;
    while (host_transfer_request_flag !== 1'b1 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    chk8("byte accepted", 8'h00, (n == 1000) ? 8'h01 : 8'h00);
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask

  task automatic take(input string what, input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge core_clk);
    while (res_valid !== 1'b1 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    chk8(what, exp, res_byte);
    res_ready = 1'b1;
    @(negedge core_clk);
    res_ready = 1'b0;
  endtask

  task automatic sense(input logic [7:0] s0, input logic [7:0] cyl);
    send(8'h08);
    take("status_zero", s0);
    take("present_cylinder", cyl);
    repeat (2) @(negedge core_clk);
    chk8("int_req cleared", 8'h00, {7'h0, int_req});
  endtask

  task automatic wait_int();
    int n;
    n = 0;
    while (int_req !== 1'b1 && n < 60000) begin
      @(negedge core_clk);
      n++;
    end
    chk8("int_req", 8'h01, {7'h0, int_req});
  endtask

  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    res_ready = 1'b0;
    xfer_byte_needed = 1'b0;
    rw_result_enter = 1'b0;
    data_rate = 3'h2;
    drive_status_register = 8'hA5;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge core_clk);
    chk8("poll int", 8'h01, {7'h0, int_req});
    chk8("buffer_disable", 8'h01, {7'h0, buffer_disable});
    chk8("implied", 8'h00, {7'h0, implied_seek_enable});
    chk8("threshold", 8'h01, {3'h0, buffer_threshold_bytes});
    chk8("precomp", 8'h00, precomp_start_track);
    sense(8'hC0, 8'h00);
    send(8'h10);
    take("version", VER_CODE);
    send(8'h04);
    send(8'h00);
    take("drive status", 8'hA5);
    send(8'h13);
    send(8'h00);
    send(8'h5F);
    send(8'hFF);
    repeat (2) @(negedge core_clk);
    chk8("implied", 8'h01, {7'h0, implied_seek_enable});
    chk8("buffer_disable", 8'h00, {7'h0, buffer_disable});
    chk8("threshold", 8'h10, {3'h0, buffer_threshold_bytes});
    chk8("precomp", 8'hFF, precomp_start_track);
    send(8'h03);
    send(8'hF0);
    send(8'h02);
    xfer_byte_needed = 1'b1;
    @(negedge core_clk);
    chk8("dma_req", 8'h01, {7'h0, dma_req});
    xfer_byte_needed = 1'b0;
    // seek with head bit set, head bit must still read zero
    send(8'h0F);
    send(8'h04);
    send(8'h05);
    wait_int();
    chk8("busy", 8'h01, {7'h0, drive_busy[0]});
    sense(8'h20, 8'h05);
    chk8("busy", 8'h00, {7'h0, drive_busy[0]});
    chk8("head", 8'h05, fcu_drive_model_i.head_pos[7:0]);
    send(8'h07);
    send(8'h00);
    wait_int();
    sense(8'h20, 8'h00);
    send(8'hCF);
    send(8'h00);
    send(8'hFF);
    wait_int();
    sense(8'h20, 8'hFF);
    send(8'hCF);
    send(8'h00);
    send(8'h03);
    wait_int();
    sense(8'h20, 8'h02);
    chk8("head", 8'h01, fcu_drive_model_i.head_pos[15:8]);
    @(negedge core_clk);
    rw_result_enter = 1'b1;
    @(negedge core_clk);
    rw_result_enter = 1'b0;
    chk8("result int", 8'h01, {7'h0, int_req});
    sense(8'h20, 8'h02);
    send(8'h03);
    send(8'hF0);
    send(8'h03);
    xfer_byte_needed = 1'b1;
    repeat (3) @(negedge core_clk);
    chk8("dma_req", 8'h00, {7'h0, dma_req});
    chk8("int_req", 8'h01, {7'h0, int_req});
    xfer_byte_needed = 1'b0;
    summarize();
  end
endmodule
